// ---- design/cpu_pkg.sv ----
/*
 compare/pwm unit package: register indices, field layout, reset values,
 mode codes and an event carrier struct.
 assumes a 32-bit axi4-lite register bus on aclk.
*/
package cpu_pkg;

	// ==========================================================
	// register printed indices (byte offsets are these times four)
	localparam logic [7:0] CPU_IDX_CMP_LOW   = 8'h15;
	localparam logic [7:0] CPU_IDX_CMP_HIGH  = 8'h16;
	localparam logic [7:0] CPU_IDX_MODE_CTRL = 8'h17;
	localparam logic [7:0] CPU_IDX_TIMER_A   = 8'h40;
	localparam logic [7:0] CPU_IDX_TIMER_B   = 8'h41;
	localparam logic [7:0] CPU_IDX_PERIOD    = 8'h42;
	localparam logic [7:0] CPU_IDX_TB_CTRL   = 8'h43;
	localparam logic [7:0] CPU_IDX_STATUS    = 8'h44;
	localparam logic [7:0] CPU_IDX_SYS_CTRL  = 8'h45;

	// ==========================================================
	// field layout
	localparam int CPU_DUTY_LSB_POS   = 4;
	localparam int CPU_TB_ON_POS      = 2;
	localparam int CPU_ST_UNIT_FLAG   = 0;
	localparam int CPU_ST_OVF_FLAG    = 1;
	localparam int CPU_ST_PIN_POS     = 2;
	localparam int CPU_SC_ENABLE_POS  = 0;
	localparam int CPU_SC_ADC_EN_POS  = 1;
	localparam int CPU_SC_SECOND_POS  = 2;
	localparam int CPU_SC_TA_RUN_POS  = 3;

	// ==========================================================
	// reset values
	localparam logic [7:0]  CPU_RST_MODE_CTRL = 8'h00;
	localparam logic [7:0]  CPU_RST_PERIOD    = 8'hFF;
	localparam logic [7:0]  CPU_RST_TB_CTRL   = 8'h00;
	localparam logic [15:0] CPU_RST_TIMER_A   = 16'h0000;

	// ==========================================================
	// mode field codes
	typedef enum logic [3:0]
	{
		CPU_MODE_OFF      = 4'b0000,
		CPU_MODE_CMP_SET  = 4'b1000,
		CPU_MODE_CMP_CLR  = 4'b1001,
		CPU_MODE_CMP_SWI  = 4'b1010,
		CPU_MODE_CMP_TRIG = 4'b1011
	} cpu_mode_t;

	// pwm is selected by the two upper mode bits alone
	localparam logic [1:0] CPU_PWM_SEL = 2'b11;

	// ==========================================================
	// bus response codes
	localparam logic [1:0] CPU_RESP_OKAY   = 2'b00;
	localparam logic [1:0] CPU_RESP_SLVERR = 2'b10;

	// ==========================================================
	// carriers
	typedef struct packed
	{
		logic        start_conv;
		logic        timer_a_reset;
		logic        unit_irq;
	} cpu_event_t;

endpackage

// ---- design/cpu_compare_pwm_unit.sv ----
/*
 compare/pwm unit with its 16-bit and 8-bit time bases, reached over axi4-lite.
 assumes aclk at 250 MHz, synchronous active-low aresetn, and a single
 bus master with at most one read and one write in flight.
*/
// The AXI4-Lite slave port was decided locally.
// Behaviour
// - compare 16-bit value against 16-bit timer continuously, flag on equality
// - mode 1000 sets pin, 1001 clears pin, 1010 flags only; all flag
// - mode 1011 fires special event trigger and sets flag
// - mode 0000 turns unit off and resets its state
// - writing zero mode control forces compare output latch low
// - software interrupt mode leaves pin alone, raises request if enabled
// - special event trigger resets 16-bit timer, giving programmable period
// - second unit trigger also starts conversion when converter enabled
// - second unit trigger reset does not set timer overflow flag
// - pwm mode produces up to ten bit duty waveform on pin
// - writing zero mode control forces pwm output latch low
// - 8-bit timer equal to period clears on next increment
// - rollover sets pin high unless duty is zero
// - rollover copies duty low register into buffered high register
// - timer postscaler plays no part in pwm period
// - duty is low compare register over mode bits five and four
// - duty writes accepted anytime, effective after next period match
// - high compare register read-only while in pwm mode
// - duty double-buffered in high register plus hidden two-bit latch
// - pin cleared when buffered duty equals timer extended by two bits
// - duty above period never clears the pin in that period
// - 8-bit timer prescale ratios one, four and sixteen
`timescale 1ns/100ps
module cpu_compare_pwm_unit
	import cpu_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output      logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        shared_output_pin,
	output      logic        unit_interrupt_request,
	output      logic        adc_start
);

	// ==========================================================
	// registers
	logic [7:0]  compare_value_low;
	logic [7:0]  compare_value_high;
	logic [7:0]  unit_mode_control;
	logic [7:0]  period_register;
	logic [7:0]  timer_b_control;
	logic [15:0] sixteen_bit_timer;
	logic [7:0]  eight_bit_timer;
	logic [3:0]  presc_cnt;
	logic [1:0]  duty_hidden;
	logic        out_latch;
	logic        unit_interrupt_flag;
	logic        timer_a_overflow_flag;
	logic [3:0]  sys_ctrl;
	logic [1:0]  phase;

	// ==========================================================
	// axi4-lite write channel state
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_idx;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// address words to printed index, only aligned low window mapped
	wire [7:0] aw_in_idx = s_axi_awaddr[9:2];
	wire [7:0] ar_in_idx = s_axi_araddr[9:2];
	wire       aw_take   = s_axi_awvalid && s_axi_awready;
	wire       w_take    = s_axi_wvalid && s_axi_wready;
	wire       wr_fire   = aw_held && w_held && !s_axi_bvalid;
	wire       wr_lane0  = wr_fire && w_strb[0];

	// decode of the write target
	wire wr_low    = wr_lane0 && (aw_idx == CPU_IDX_CMP_LOW);
	wire wr_high   = wr_lane0 && (aw_idx == CPU_IDX_CMP_HIGH);
	wire wr_mode   = wr_lane0 && (aw_idx == CPU_IDX_MODE_CTRL);
	wire wr_period = wr_lane0 && (aw_idx == CPU_IDX_PERIOD);
	wire wr_tbctl  = wr_lane0 && (aw_idx == CPU_IDX_TB_CTRL);
	wire wr_tmra   = wr_fire && (aw_idx == CPU_IDX_TIMER_A);
	wire wr_tmrb   = wr_lane0 && (aw_idx == CPU_IDX_TIMER_B);
	wire wr_status = wr_lane0 && (aw_idx == CPU_IDX_STATUS);
	wire wr_sys    = wr_lane0 && (aw_idx == CPU_IDX_SYS_CTRL);
	wire wr_known  = wr_low || wr_high || wr_mode || wr_period || wr_tbctl
		|| wr_tmra || wr_tmrb || wr_status || wr_sys
		|| (aw_idx == CPU_IDX_TIMER_A);

	// ==========================================================
	// mode decode
	wire [3:0] mode_field = unit_mode_control[3:0];
	wire       pwm_mode   = (mode_field[3:2] == CPU_PWM_SEL);
	wire       cmp_mode   = (mode_field[3:2] == 2'b10);
	wire       unit_off   = (mode_field == CPU_MODE_OFF);
	wire       tb_on      = timer_b_control[CPU_TB_ON_POS];
	wire       ta_run     = sys_ctrl[CPU_SC_TA_RUN_POS];
	wire       is_second  = sys_ctrl[CPU_SC_SECOND_POS];

	// compare match; only meaningful in compare modes
	wire cmp_match = cmp_mode && (sixteen_bit_timer == {compare_value_high,
		compare_value_low});
	wire trig_evt  = cmp_match && (mode_field == CPU_MODE_CMP_TRIG);

	// ==========================================================
	// 8-bit time base: a step per four core phases times 1/4/16, no postscaler
	wire [3:0] presc_lim  = timer_b_control[1] ? 4'hF :
		(timer_b_control[0] ? 4'h3 : 4'h0);
	wire       cyc_end    = (phase == 2'b11);
	wire       tb_tick    = tb_on && cyc_end && (presc_cnt == presc_lim);
	wire       per_match  = (eight_bit_timer == period_register);
	wire       rollover   = tb_tick && per_match;
	wire [1:0] next_phase = phase + 2'b01;
	wire [3:0] next_presc = (!tb_on || tb_tick) ? 4'h0 :
		(cyc_end ? presc_cnt + 4'h1 : presc_cnt);
	wire [7:0] next_tb    = wr_tmrb ? w_data[7:0] : (rollover ? 8'h00 :
		(tb_tick ? eight_bit_timer + 8'h01 : eight_bit_timer));
	// extension bits: core phase at 1:1, prescaler bits at 1:4 and 1:16
	wire [1:0] next_ext   = (presc_lim == 4'h0) ? next_phase :
		(timer_b_control[1] ? next_presc[3:2] : next_presc[1:0]);
	wire [9:0] duty_buf   = {compare_value_high, duty_hidden};
	wire [9:0] duty_next  = {compare_value_low,
		unit_mode_control[CPU_DUTY_LSB_POS+1:CPU_DUTY_LSB_POS]};
	// matched against the count the coming edge loads, so the pin falls with
	// it; a duty beyond the period is never reached by the count
	wire       duty_hit   = tb_on && ({next_tb, next_ext} == duty_buf);

	// ==========================================================
	// bus handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_idx        <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= CPU_RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held <= 1'b1;
				aw_idx  <= (s_axi_awaddr[1:0] == 2'b00 && s_axi_awaddr[31:10] == '0)
					? aw_in_idx : 8'hFF;
			end
			if (w_take)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? CPU_RESP_OKAY : CPU_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// readies registered from next state: none shows while its own slot is full or its channel's answer waits
	wire next_aw_held = aw_take || (aw_held && !wr_fire);
	wire next_w_held  = w_take || (w_held && !wr_fire);
	wire next_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);
	wire next_rvalid  = (s_axi_arvalid && s_axi_arready)
		|| (s_axi_rvalid && !s_axi_rready);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready  <= !next_w_held && !next_bvalid;
			s_axi_arready <= !next_rvalid;
		end
	end

	// ==========================================================
	// read path
	logic [31:0] rd_word;
	logic        rd_ok;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (ar_in_idx)
			CPU_IDX_CMP_LOW:   rd_word[7:0]  = compare_value_low;
			CPU_IDX_CMP_HIGH:  rd_word[7:0]  = compare_value_high;
			CPU_IDX_MODE_CTRL: rd_word[7:0]  = {2'b00, unit_mode_control[5:0]};
			CPU_IDX_TIMER_A:   rd_word[15:0] = sixteen_bit_timer;
			CPU_IDX_TIMER_B:   rd_word[7:0]  = eight_bit_timer;
			CPU_IDX_PERIOD:    rd_word[7:0]  = period_register;
			CPU_IDX_TB_CTRL:   rd_word[7:0]  = timer_b_control;
			CPU_IDX_STATUS:    rd_word[2:0]  = {out_latch, timer_a_overflow_flag,
				unit_interrupt_flag};
			CPU_IDX_SYS_CTRL:  rd_word[3:0]  = sys_ctrl;
			default:           rd_ok         = 1'b0;
		endcase
		if (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr[31:10] != '0)
			rd_ok = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= CPU_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
			s_axi_rresp  <= rd_ok ? CPU_RESP_OKAY : CPU_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================================
	// software-held configuration
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			compare_value_low <= 8'h00;
			unit_mode_control <= CPU_RST_MODE_CTRL;
			period_register   <= CPU_RST_PERIOD;
			timer_b_control   <= CPU_RST_TB_CTRL;
			sys_ctrl          <= 4'h0;
		end
		else
		begin
			if (wr_low)
				compare_value_low <= w_data[7:0];
			if (wr_mode)
				unit_mode_control <= {2'b00, w_data[5:0]};
			if (wr_period)
				period_register <= w_data[7:0];
			if (wr_tbctl)
				timer_b_control <= {1'b0, w_data[6:0]};
			if (wr_sys)
				sys_ctrl <= w_data[3:0];
		end
	end

	// ==========================================================
	// high compare byte: software value in compare, duty buffer in pwm
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			compare_value_high <= 8'h00;
			duty_hidden        <= 2'b00;
		end
		else if (pwm_mode && rollover)
		begin
			compare_value_high <= duty_next[9:2];
			duty_hidden        <= duty_next[1:0];
		end
		else if (wr_high && !pwm_mode)
			compare_value_high <= w_data[7:0];
	end

	// ==========================================================
	// 16-bit time base; the trigger reset wins over a software write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sixteen_bit_timer <= CPU_RST_TIMER_A;
		else if (trig_evt)
			sixteen_bit_timer <= CPU_RST_TIMER_A;
		else if (wr_tmra)
			sixteen_bit_timer <= w_data[15:0];
		else if (ta_run)
			sixteen_bit_timer <= sixteen_bit_timer + 16'h0001;
	end

	// ==========================================================
	// 8-bit time base and core phase
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			eight_bit_timer <= 8'h00;
			presc_cnt       <= 4'h0;
			phase           <= 2'b00;
		end
		else
		begin
			phase           <= next_phase;
			eight_bit_timer <= next_tb;
			presc_cnt       <= next_presc;
		end
	end

	// ==========================================================
	// flags: hardware set wins over software clear (write one to clear)
	wire ovf_evt = ta_run && !trig_evt && (sixteen_bit_timer == 16'hFFFF);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			unit_interrupt_flag   <= 1'b0;
			timer_a_overflow_flag <= 1'b0;
		end
		else
		begin
			if (cmp_match)
				unit_interrupt_flag <= 1'b1;
			else if (wr_status && w_data[CPU_ST_UNIT_FLAG])
				unit_interrupt_flag <= 1'b0;
			// trigger resets never count as overflow
			if (ovf_evt)
				timer_a_overflow_flag <= 1'b1;
			else if (wr_status && w_data[CPU_ST_OVF_FLAG])
				timer_a_overflow_flag <= 1'b0;
		end
	end

	// ==========================================================
	// output latch, separate from any port data latch
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			out_latch <= 1'b0;
		else if (unit_off || (mode_field[3] == 1'b0))
			out_latch <= 1'b0;
		else if (pwm_mode)
		begin
			if (rollover)
				out_latch <= (duty_next != 10'h000);
			else if (duty_hit)
				out_latch <= 1'b0;
		end
		else if (cmp_match && mode_field == CPU_MODE_CMP_SET)
			out_latch <= 1'b1;
		else if (cmp_match && mode_field == CPU_MODE_CMP_CLR)
			out_latch <= 1'b0;
		// software interrupt and trigger modes hold the pin
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shared_output_pin      <= 1'b0;
			unit_interrupt_request <= 1'b0;
			adc_start              <= 1'b0;
		end
		else
		begin
			shared_output_pin      <= out_latch;
			unit_interrupt_request <= unit_interrupt_flag
				&& sys_ctrl[CPU_SC_ENABLE_POS];
			adc_start              <= trig_evt && is_second
				&& sys_ctrl[CPU_SC_ADC_EN_POS];
		end
	end

endmodule

// ---- test/cpu_checker.sv ----
/*
 checker for the compare/pwm unit: register bus handshakes and payloads.
 assumes a bind onto cpu_compare_pwm_unit, one clock aclk.
*/
`timescale 1ns/100ps
module cpu_checker
	import cpu_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	// ==========================================
	// one domain, so clock and reset given once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// completed transfers as named steps
	sequence s_wr_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	sequence s_rd_done;
		s_axi_rvalid && s_axi_rready;
	endsequence

	// answers stand until taken
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer changed");
	// read answered one cycle after the address is taken
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// refusals while an answer is pending
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	// a taken answer is withdrawn at once
	a_write_closes: assert property (s_wr_done |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_read_closes: assert property (s_rd_done |=> !s_axi_rvalid)
		else $error("read answer repeated");
	// an error read carries no stale data
	a_err_no_data: assert property (s_axi_rvalid && s_axi_rresp == CPU_RESP_SLVERR
		|-> s_axi_rdata == 32'h0000_0000) else $error("error read with data");
endmodule

bind cpu_compare_pwm_unit cpu_checker u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);

// ---- test/cpu_pin_load.sv ----
/*
 load on the shared output pin: counts rises, measures pulse and period.
 assumes the pin is sampled on aclk; the load never drives back.
*/
`timescale 1ns/100ps
module cpu_pin_load (
	input  wire logic        aclk,
	input  wire logic        pin,
	output      logic [15:0] rises = 16'h0000,
	output      logic [15:0] high_len = 16'h0000,
	output      logic [15:0] per_len = 16'h0000
);
	logic        last = 1'b0;
	logic [15:0] hi_cnt = 16'h0000;
	logic [15:0] per_cnt = 16'h0000;

	// ==========================================
	// edge-to-edge timing; counts in aclk cycles
	always @(posedge aclk)
	begin
		last <= pin;
		hi_cnt <= pin ? hi_cnt + 16'h0001 : 16'h0000;
		per_cnt <= per_cnt + 16'h0001;
		if (pin && !last)
		begin
			rises <= rises + 16'h0001;
			per_len <= per_cnt + 16'h0001;
			per_cnt <= 16'h0000;
		end
		if (!pin && last)
			high_len <= hi_cnt;
	end
endmodule

// ---- test/testbench.sv ----
/*
 self-checking bench for the compare/pwm unit over axi4-lite.
 assumes cpu_pkg, the unit and the pin load are compiled first.
*/
`timescale 1ns/100ps
module testbench
	import cpu_pkg::*;
;
	localparam logic [31:0] A_LO = {22'h0, CPU_IDX_CMP_LOW, 2'b00};
	localparam logic [31:0] A_HI = {22'h0, CPU_IDX_CMP_HIGH, 2'b00};
	localparam logic [31:0] A_MODE = {22'h0, CPU_IDX_MODE_CTRL, 2'b00};
	localparam logic [31:0] A_TA = {22'h0, CPU_IDX_TIMER_A, 2'b00};
	localparam logic [31:0] A_TB = {22'h0, CPU_IDX_TIMER_B, 2'b00};
	localparam logic [31:0] A_PER = {22'h0, CPU_IDX_PERIOD, 2'b00};
	localparam logic [31:0] A_TBC = {22'h0, CPU_IDX_TB_CTRL, 2'b00};
	localparam logic [31:0] A_ST = {22'h0, CPU_IDX_STATUS, 2'b00};
	localparam logic [31:0] A_SC = {22'h0, CPU_IDX_SYS_CTRL, 2'b00};
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [31:0] awaddr = 32'h0000_0000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] araddr = 32'h0000_0000;
	logic        awready, wready, bvalid, arready, rvalid, pin, irq, adc;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] rises, high_len, per_len;
	int          failures = 0;
	int          n_tests = 0;
	cpu_mode_t   md [4] = '{CPU_MODE_CMP_SET, CPU_MODE_CMP_SWI, CPU_MODE_CMP_CLR,
		CPU_MODE_CMP_SET};

	cpu_compare_pwm_unit u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .shared_output_pin(pin),
		.unit_interrupt_request(irq), .adc_start(adc)
	);
	// the load only listens: the pin is an output of the unit alone
	cpu_pin_load u_load (
		.aclk(aclk), .pin(pin), .rises(rises), .high_len(high_len), .per_len(per_len)
	);

	// ==========================================
	// 250 MHz clock
	initial
	begin
		forever #2 aclk = ~aclk;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ==========================================
	// bus cycles; bready and rready stay high, so no same-step re-drive
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] er = CPU_RESP_OKAY);
		bit pa;
		bit pw;
		pa = 1'b1;
		pw = 1'b1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		do
		begin
			@(posedge aclk);
			if (pa && awready)
			begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && wready)
			begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		while (!bvalid);
		chk(32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		input logic [1:0] er = CPU_RESP_OKAY);
		arvalid <= 1'b1;
		araddr <= a;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		chk(32'(rresp), 32'(er));
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		logic [31:0] d;
		rd(A_MODE, d);
		chk(d, 32'(CPU_RST_MODE_CTRL));
		rd(A_PER, d);
		chk(d, 32'(CPU_RST_PERIOD));
		rd(32'h0000_0200, d, CPU_RESP_SLVERR);
		chk(d, 32'h0000_0000);
		wr(32'h0000_0204, 32'h0000_00FF, CPU_RESP_SLVERR);
		$display("test regs done");
	endtask

	task automatic t_compare();
		logic [31:0] d;
		wr(A_LO, 32'h0000_0040);
		wr(A_HI, 32'h0000_0001);
		for (int i = 0; i < 4; i++)
		begin
			wr(A_SC, (i == 1) ? 32'h0000_0008 : 32'h0000_0009);
			wr(A_TA, 32'h0000_0000);
			wr(A_ST, 32'h0000_0003);
			wr(A_MODE, 32'(md[i]));
			repeat (400) @(posedge aclk);
			rd(A_ST, d);
			chk(d, {29'h0, i != 2, 2'b01});
			chk(32'(pin), 32'(i != 2));
			chk(32'(irq), 32'(i != 1));
		end
		wr(A_MODE, 32'h0000_0000);
		rd(A_ST, d);
		chk(32'(d[2]), 32'h0000_0000);
		chk(32'(pin), 32'h0000_0000);
		wr(A_SC, 32'h0000_0000);
		$display("test compare done");
	endtask

	task automatic count_adc(input int c, output int n);
		n = 0;
		repeat (c)
		begin
			@(posedge aclk);
			n += int'(adc);
		end
	endtask

	task automatic t_trigger();
		logic [31:0] d;
		int n;
		wr(A_LO, 32'h0000_0030);
		wr(A_HI, 32'h0000_0000);
		wr(A_ST, 32'h0000_0003);
		wr(A_SC, 32'h0000_000F);
		wr(A_TA, 32'h0000_0000);
		wr(A_MODE, 32'(CPU_MODE_CMP_TRIG));
		count_adc(400, n);
		chk(32'(n > 5), 32'h0000_0001);
		rd(A_TA, d);
		chk(32'(d < 32'h0000_0031), 32'h0000_0001);
		rd(A_ST, d);
		chk(32'(d[1:0]), 32'h0000_0001);
		wr(A_SC, 32'h0000_000D);
		count_adc(200, n);
		chk(32'(n), 32'h0000_0000);
		// a trigger at the top count must not read as an overflow
		wr(A_SC, 32'h0000_000F);
		wr(A_LO, 32'h0000_00FF);
		wr(A_HI, 32'h0000_00FF);
		wr(A_ST, 32'h0000_0003);
		wr(A_TA, 32'h0000_FFF0);
		count_adc(40, n);
		chk(32'(n), 32'h0000_0001);
		rd(A_ST, d);
		chk(32'(d[1:0]), 32'h0000_0001);
		wr(A_MODE, 32'h0000_0000);
		wr(A_SC, 32'h0000_0000);
		$display("test trigger done");
	endtask

	// pwm set-up in the safe order; postscaler bits set on purpose
	task automatic set_pwm(input logic [7:0] pr, input logic [1:0] ps,
		input logic [7:0] dl, input logic [7:0] m);
		wr(A_MODE, 32'h0000_0000);
		repeat (4) @(posedge aclk);
		chk(32'(pin), 32'h0000_0000);
		wr(A_PER, 32'(pr));
		wr(A_LO, 32'(dl));
		wr(A_TBC, 32'h0000_007C | 32'(ps));
		wr(A_TB, 32'h0000_0000);
		wr(A_MODE, 32'(m));
		repeat (900) @(posedge aclk);
	endtask

	task automatic t_pwm();
		logic [15:0] r0;
		logic [31:0] d;
		set_pwm(8'h03, 2'b00, 8'h02, 8'h0C);
		chk(32'(per_len), 32'h0000_0010);
		chk(32'(high_len), 32'h0000_0008);
		set_pwm(8'h07, 2'b00, 8'h01, 8'h2C);
		chk(32'(per_len), 32'h0000_0020);
		chk(32'(high_len), 32'h0000_0006);
		set_pwm(8'h03, 2'b01, 8'h02, 8'h0F);
		chk(32'(per_len), 32'h0000_0040);
		chk(32'(high_len), 32'h0000_0020);
		set_pwm(8'h03, 2'b10, 8'h02, 8'h0D);
		chk(32'(per_len), 32'h0000_0100);
		chk(32'(high_len), 32'h0000_0080);
		for (int i = 0; i < 2; i++)
		begin
			set_pwm(8'h03, 2'b00, (i == 0) ? 8'h00 : 8'h10, 8'h0C);
			r0 = rises;
			repeat (100) @(posedge aclk);
			chk(32'(rises), 32'(r0));
			chk(32'(pin), 32'(i));
		end
		set_pwm(8'h3F, 2'b10, 8'h02, 8'h0C);
		// a period is 4096 cycles here: let the first copy land first
		repeat (4200) @(posedge aclk);
		wr(A_LO, 32'h0000_0005);
		wr(A_HI, 32'h0000_0055);
		rd(A_HI, d);
		chk(d, 32'h0000_0002);
		repeat (4200) @(posedge aclk);
		rd(A_HI, d);
		chk(d, 32'h0000_0005);
		wr(A_MODE, 32'h0000_0000);
		$display("test pwm done");
	endtask

	// ==========================================
	// main sequence and watchdog
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		bready <= 1'b1;
		rready <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_compare();
		t_trigger();
		t_pwm();
		finish_test();
	end

	initial
	begin
		repeat (40000) @(posedge aclk);
		failures++;
		finish_test();
	end
endmodule
